// *** hdl/ppisc_regs.svh ***
// constants for the process image status and control block
`ifndef PPISC_REGS_SVH
`define PPISC_REGS_SVH

// process image byte addresses
`define PPISC_STATUS_LO_OFS   1'h0
`define PPISC_STATUS_HI_OFS   1'h1

// output word (from controller) bit positions
`define PPISC_CMD_ALARM1_BIT  6
`define PPISC_CMD_ALARM2_BIT  7
`define PPISC_CMD_MRST_BIT    8

// status byte n bit positions
`define PPISC_LO_FAULT_BIT    0
`define PPISC_LO_OUT3_BIT     4
`define PPISC_LO_OUT4_BIT     5
`define PPISC_LO_OUT1_BIT     6
`define PPISC_LO_OUT2_BIT     7

// reset values
`define PPISC_STATUS_RST      8'h00
`define PPISC_DOUT_RST        4'h0

// timing
`define PPISC_CLK_HZ          20000000
`define PPISC_ALARM_HOLD_S    4
`define PPISC_MRST_CYCLES     5'h10

`endif

// *** hdl/ppisc_pkg.sv ***
// types for the process image status and control block
package ppisc_pkg;

    typedef enum logic [1:0] {
        MODE_HOST_USB = 2'b00,
        MODE_REMOTE   = 2'b01,
        MODE_PASS     = 2'b10
    } ppisc_mode_t;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_SEND   = 2'b01,
        ST_WAIT   = 2'b10,
        ST_HANGUP = 2'b11
    } ppisc_state_t;

    typedef struct packed {
        logic power;
        logic signed_on;
        logic traffic;
        logic off_hook;
        logic carrier;
    } ppisc_led_t;

    typedef struct packed {
        logic [7:0] hi;
        logic [7:0] lo;
    } ppisc_image_t;

endpackage

// *** hdl/ppisc_sync.sv ***
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module ppisc_sync #(
    parameter int WIDTH = 3
) (
    // clock and reset
    input  wire logic             mclk,
    input  wire logic             nrst,
    // pins in, synchronised out
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= pin_in;
            sync_out <= meta_reg;
        end
    end

endmodule

// *** hdl/ppisc_alarm_hold.sv ***
// qualifies one alarm input by a continuous hold time
`timescale 1ns/1ps
module ppisc_alarm_hold #(
    parameter int HOLD_CYCLES = 80000000
) (
    // clock and reset
    input  wire logic mclk,
    input  wire logic nrst,
    // alarm level in, qualified pulse out
    input  wire logic level_in,
    output logic      qual_pulse
);

    localparam logic [26:0] HOLD_LAST = 27'(HOLD_CYCLES - 1);

    logic [26:0] cnt_reg;
    logic        done_reg;

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            cnt_reg    <= 27'h0000000;
            done_reg   <= 1'b0;
            qual_pulse <= 1'b0;
        end else begin
            qual_pulse <= 1'b0;
            if (!level_in) begin
                cnt_reg  <= 27'h0000000;
                done_reg <= 1'b0;
            end else if (!done_reg) begin
                if (cnt_reg == HOLD_LAST) begin
                    qual_pulse <= 1'b1;
                    done_reg   <= 1'b1;
                end else begin
                    cnt_reg <= cnt_reg + 27'h0000001;
                end
            end
        end
    end

    held_count_a: assert property (@(posedge mclk) disable iff (!nrst)
        qual_pulse |-> $past(cnt_reg) == HOLD_LAST && $past(level_in))
        else $error("alarm qualified before hold time");
    drop_restart_a: assert property (@(posedge mclk) disable iff (!nrst)
        !level_in |=> cnt_reg == 27'h0000000 && !qual_pulse)
        else $error("hold count not restarted on drop");

endmodule

// *** hdl/ppisc_top.sv ***
// process image status and control bank between service module and controller
//
// Operation
// - alarm 1 is processed only after four seconds of continuous assertion.
// - alarm 2 is processed only after four seconds of continuous assertion.
// - after a text message alarm is sent, the connection is ended at once.
// - a 1 in bit 0 of output byte n+1 starts a modem reset.
// - all other output word bits have no effect.
// - status byte n reads at address 0, byte n+1 at address 1.
// - bit 0 of status byte n flags an internal communication error.
// - while that flag is set every other status bit reads 0.
// - bits 1 to 3 of status byte n are reserved and read 0.
// - status byte n bits 4..7 mirror outputs 3, 4, 1, 2.
// - four digital outputs can be set remotely by service software.
// - output 1 is closed while a pulse alarm is processed.
// - status byte n+1 bits 0..2 show power, sign-on and bus traffic.
// - bit 3 shows off-hook, bit 4 shows modem carrier ready.
// - off-hook and carrier bits are sent only while the modem takes part.
// - bits 5..7 of status byte n+1 show the operating mode one-hot.
// - a mode imposed by service software is reported instead of the switch.
// - output byte n bit 6 is alarm input 1, bit 7 alarm input 2.
// - process image is exchanged only when the io enable switch is on.
`timescale 1ns/1ps
`include "ppisc_regs.svh"
module ppisc_top
    import ppisc_pkg::*;
#(
    parameter int HOLD_CYCLES = `PPISC_ALARM_HOLD_S * `PPISC_CLK_HZ
) (
    // clock and reset
    input  wire logic         mclk,
    input  wire logic         nrst,
    // switches on the front panel
    input  wire logic         io_enable_switch,
    input  wire logic [1:0]   mode_switch,
    // controller output word and status read port
    input  wire logic [15:0]  cmd_word,
    input  wire logic         rd_addr,
    output logic      [7:0]   rd_data_reg,
    output ppisc_image_t      status_word_reg,
    // internal status from the module
    input  wire logic         comm_fault,
    input  ppisc_led_t        led_state,
    input  wire logic         modem_involved,
    input  wire logic         forced_mode_valid,
    input  ppisc_mode_t       forced_mode,
    // service software outputs and pulse alarm
    input  wire logic [3:0]   remote_out_set,
    input  wire logic         pulse_alarm_active,
    // alarm dispatch to modem
    input  wire logic         sms_delivery,
    input  wire logic         msg_done,
    output logic              alarm_start_reg,
    output logic              alarm_id_reg,
    output logic              call_end_reg,
    output logic              modem_reset_reg,
    // digital outputs and mode indicator
    output logic      [3:0]   dout_reg,
    output logic              mode_led_green_reg,
    output logic              mode_led_red_reg
);

    logic [2:0]   pin_sync;
    logic         io_en;
    ppisc_mode_t  switch_mode;
    ppisc_mode_t  active_mode;
    logic [15:0]  cmd_eff;
    logic         alarm1_qual;
    logic         alarm2_qual;
    logic         pend1_reg;
    logic         pend2_reg;
    ppisc_state_t state_reg;
    ppisc_state_t state_next;
    logic         mrst_prev_reg;
    logic [4:0]   mrst_cnt_reg;
    logic [2:0]   mode_onehot;
    logic [3:0]   dout_next;
    logic [7:0]   lo_next;
    logic [7:0]   hi_next;

    // pin synchronisation
    ppisc_sync #(
        .WIDTH (3)
    ) u_sync (
        .mclk     (mclk),
        .nrst     (nrst),
        .pin_in   ({io_enable_switch, mode_switch}),
        .sync_out (pin_sync)
    );

    assign io_en       = pin_sync[2];
    assign switch_mode = (pin_sync[1:0] == 2'b11) ? MODE_REMOTE : ppisc_mode_t'(pin_sync[1:0]);

    assign active_mode = forced_mode_valid ? forced_mode : switch_mode;

    assign cmd_eff = io_en ? cmd_word : 16'h0000;

    // alarm inputs from output byte n
    ppisc_alarm_hold #(
        .HOLD_CYCLES (HOLD_CYCLES)
    ) u_alarm1 (
        .mclk       (mclk),
        .nrst       (nrst),
        .level_in   (cmd_eff[`PPISC_CMD_ALARM1_BIT]),
        .qual_pulse (alarm1_qual)
    );

    ppisc_alarm_hold #(
        .HOLD_CYCLES (HOLD_CYCLES)
    ) u_alarm2 (
        .mclk       (mclk),
        .nrst       (nrst),
        .level_in   (cmd_eff[`PPISC_CMD_ALARM2_BIT]),
        .qual_pulse (alarm2_qual)
    );

    // pending alarms, set wins over clear
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            pend1_reg <= 1'b0;
            pend2_reg <= 1'b0;
        end else begin
            if (alarm1_qual) begin
                pend1_reg <= 1'b1;
            end else if (state_reg == ST_SEND && !alarm_id_reg) begin
                pend1_reg <= 1'b0;
            end
            if (alarm2_qual) begin
                pend2_reg <= 1'b1;
            end else if (state_reg == ST_SEND && alarm_id_reg) begin
                pend2_reg <= 1'b0;
            end
        end
    end

    // alarm dispatch sequencer
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (pend1_reg || pend2_reg) begin
                    state_next = ST_SEND;
                end
            end
            ST_SEND: begin
                state_next = ST_WAIT;
            end
            ST_WAIT: begin
                if (msg_done) begin
                    state_next = sms_delivery ? ST_HANGUP : ST_IDLE;
                end
            end
            ST_HANGUP: begin
                state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            alarm_start_reg <= 1'b0;
            alarm_id_reg    <= 1'b0;
            call_end_reg    <= 1'b0;
        end else begin
            alarm_start_reg <= (state_next == ST_SEND);
            if (state_reg == ST_IDLE && state_next == ST_SEND) begin
                alarm_id_reg <= !pend1_reg;
            end
            call_end_reg <= (state_next == ST_HANGUP);
        end
    end

    // modem reset on rising edge of the reset bit
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            mrst_prev_reg   <= 1'b0;
            mrst_cnt_reg    <= 5'h00;
            modem_reset_reg <= 1'b0;
        end else begin
            mrst_prev_reg <= cmd_eff[`PPISC_CMD_MRST_BIT];
            if (cmd_eff[`PPISC_CMD_MRST_BIT] && !mrst_prev_reg) begin
                mrst_cnt_reg    <= `PPISC_MRST_CYCLES;
                modem_reset_reg <= 1'b1;
            end else if (mrst_cnt_reg != 5'h00) begin
                mrst_cnt_reg    <= mrst_cnt_reg - 5'h01;
                modem_reset_reg <= (mrst_cnt_reg != 5'h01);
            end else begin
                modem_reset_reg <= 1'b0;
            end
        end
    end
    // remaining cmd_word bits are not decoded anywhere

    // remote outputs, output 1 closed during pulse alarm
    assign dout_next = {remote_out_set[3:1], remote_out_set[0] | pulse_alarm_active};

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            dout_reg <= `PPISC_DOUT_RST;
        end else begin
            dout_reg <= dout_next;
        end
    end

    always_comb begin
        mode_onehot = 3'b000;
        case (active_mode)
            MODE_HOST_USB: begin
                mode_onehot = 3'b001;
            end
            MODE_REMOTE: begin
                mode_onehot = 3'b010;
            end
            MODE_PASS: begin
                mode_onehot = 3'b100;
            end
            default: begin
                mode_onehot = 3'b010;
            end
        endcase
    end

    // status byte assembly
    always_comb begin
        lo_next = `PPISC_STATUS_RST;
        hi_next = `PPISC_STATUS_RST;
        if (!io_en) begin
            lo_next = `PPISC_STATUS_RST;
            hi_next = `PPISC_STATUS_RST;
        end else if (comm_fault) begin
            lo_next[`PPISC_LO_FAULT_BIT] = 1'b1;
        end else begin
            // bits 1..3 stay 0, output mirrors
            lo_next[`PPISC_LO_OUT3_BIT] = dout_next[2];
            lo_next[`PPISC_LO_OUT4_BIT] = dout_next[3];
            lo_next[`PPISC_LO_OUT1_BIT] = dout_next[0];
            lo_next[`PPISC_LO_OUT2_BIT] = dout_next[1];
            hi_next[0] = led_state.power;
            hi_next[1] = led_state.signed_on;
            hi_next[2] = led_state.traffic;
            // modem lamps only while modem takes part
            hi_next[3] = led_state.off_hook & modem_involved;
            hi_next[4] = led_state.carrier & modem_involved;
            hi_next[7:5] = mode_onehot;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            status_word_reg.lo <= `PPISC_STATUS_RST;
            status_word_reg.hi <= `PPISC_STATUS_RST;
        end else begin
            status_word_reg.lo <= lo_next;
            status_word_reg.hi <= hi_next;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            rd_data_reg <= `PPISC_STATUS_RST;
        end else if (rd_addr == `PPISC_STATUS_HI_OFS) begin
            rd_data_reg <= status_word_reg.hi;
        end else begin
            rd_data_reg <= status_word_reg.lo;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            mode_led_green_reg <= 1'b0;
            mode_led_red_reg   <= 1'b0;
        end else begin
            mode_led_green_reg <= (active_mode == MODE_HOST_USB);
            mode_led_red_reg   <= (active_mode == MODE_PASS);
        end
    end

    // checks
    fault_flag_a: assert property (@(posedge mclk) disable iff (!nrst)
        io_en && comm_fault |=> status_word_reg.lo[0])
        else $error("fault flag not set");
    fault_clears_a: assert property (@(posedge mclk) disable iff (!nrst)
        status_word_reg.lo[0] |-> status_word_reg.lo[7:1] == 7'h00
            && status_word_reg.hi == 8'h00)
        else $error("status bits not cleared on fault");
    reserved_zero_a: assert property (@(posedge mclk) disable iff (!nrst)
        status_word_reg.lo[3:1] == 3'h0)
        else $error("reserved status bits set");
    out_mirror_a: assert property (@(posedge mclk) disable iff (!nrst)
        status_word_reg.lo[6] |-> dout_reg[0])
        else $error("output 1 mirror mismatch");
    out1_pulse_a: assert property (@(posedge mclk) disable iff (!nrst)
        pulse_alarm_active |=> dout_reg[0])
        else $error("output 1 open during pulse alarm");
    modem_iso_a: assert property (@(posedge mclk) disable iff (!nrst)
        !modem_involved |=> status_word_reg.hi[4:3] == 2'h0)
        else $error("modem lamps sent while modem idle");
    mode_onehot_a: assert property (@(posedge mclk) disable iff (!nrst)
        status_word_reg.hi[7:5] != 3'h0 |-> $onehot(status_word_reg.hi[7:5]))
        else $error("mode bits not one-hot");
    forced_mode_a: assert property (@(posedge mclk) disable iff (!nrst)
        forced_mode_valid && forced_mode == MODE_PASS |=> mode_led_red_reg)
        else $error("imposed mode not reported");
    io_off_a: assert property (@(posedge mclk) disable iff (!nrst)
        !io_en |=> status_word_reg == 16'h0000)
        else $error("status sent while io disabled");
    hangup_after_a: assert property (@(posedge mclk) disable iff (!nrst)
        state_reg == ST_WAIT && msg_done && sms_delivery |=> call_end_reg ##1 !call_end_reg)
        else $error("connection not ended after text message");
    mrst_hold_a: assert property (@(posedge mclk) disable iff (!nrst)
        $rose(modem_reset_reg) |-> modem_reset_reg [*8])
        else $error("modem reset too short");
    addr_map_a: assert property (@(posedge mclk) disable iff (!nrst)
        rd_addr |=> rd_data_reg == $past(status_word_reg.hi))
        else $error("address 1 not mapped to byte n+1");

    alarm_sent_c: cover property (@(posedge mclk) disable iff (!nrst) alarm_start_reg);
    hangup_c: cover property (@(posedge mclk) disable iff (!nrst) call_end_reg);
    fault_c: cover property (@(posedge mclk) disable iff (!nrst) status_word_reg.lo[0]);
    mrst_c: cover property (@(posedge mclk) disable iff (!nrst) $rose(modem_reset_reg));

endmodule

// *** dv/ppisc_modem_model.sv ***
// modem side model: reports the alarm message sent after a delay
`timescale 1ns/1ps
module ppisc_modem_model #(
    parameter int DELAY = 3
) (
    // clock and reset
    input  wire logic mclk,
    input  wire logic nrst,
    // alarm start in, message done out
    input  wire logic alarm_start,
    output logic      msg_done
);
    int cnt;
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            cnt      <= 0;
            msg_done <= 1'h0;
        end else begin
            msg_done <= (cnt == 1);
            if (alarm_start) begin
                cnt <= DELAY;
            end else if (cnt > 0) begin
                cnt <= cnt - 1;
            end
        end
    end
endmodule

// *** dv/test_plc_process_image_status_control.sv ***
// self-checking bench for the process image status and control bank
`timescale 1ns/1ps
module test_plc_process_image_status_control;
    import ppisc_pkg::*;
    localparam int HOLD = 20;
    typedef struct packed {
        logic flt; logic [3:0] oset; logic pls; logic [4:0] led; logic inv;
        logic [1:0] sw; logic fv; ppisc_mode_t fm;
        logic [7:0] lo; logic [7:0] hi; logic [3:0] dout; logic [1:0] gr;
    } ppisc_row_t;
    logic mclk = 1'h0, nrst = 1'h0, io_en = 1'h1, rd_addr = 1'h0;
    logic [1:0] mode_sw = 2'h0;
    logic [15:0] cmd_word = 16'h0000;
    logic comm_fault = 1'h0, inv = 1'h0, fv = 1'h0, pls = 1'h0, sms = 1'h0, msg_done;
    logic [4:0] led = 5'h00;
    logic [3:0] oset = 4'h0;
    ppisc_mode_t fm = MODE_HOST_USB;
    logic [7:0] rd_data_reg;
    ppisc_image_t status_word_reg;
    logic alarm_start_reg, alarm_id_reg, call_end_reg, modem_reset_reg, gled, rled, id;
    logic [3:0] dout_reg;
    int n_mismatch = 0, compares = 0, ns, ne, fs, nr;
    ppisc_row_t rows [6] = '{
        '{1'h0, 4'h0, 1'h0, 5'h00, 1'h0, 2'h0, 1'h0, MODE_HOST_USB, 8'h00, 8'h20, 4'h0, 2'h2},
        '{1'h0, 4'h1, 1'h0, 5'h1F, 1'h1, 2'h1, 1'h0, MODE_HOST_USB, 8'h40, 8'h5F, 4'h1, 2'h0},
        '{1'h0, 4'hE, 1'h0, 5'h1F, 1'h0, 2'h2, 1'h0, MODE_HOST_USB, 8'hB0, 8'h87, 4'hE, 2'h1},
        '{1'h0, 4'h0, 1'h1, 5'h03, 1'h1, 2'h3, 1'h0, MODE_HOST_USB, 8'h40, 8'h58, 4'h1, 2'h0},
        '{1'h0, 4'h8, 1'h0, 5'h10, 1'h0, 2'h0, 1'h1, MODE_PASS, 8'h20, 8'h81, 4'h8, 2'h1},
        '{1'h1, 4'hF, 1'h1, 5'h1F, 1'h1, 2'h1, 1'h0, MODE_HOST_USB, 8'h01, 8'h00, 4'hF, 2'h0}
    };

    always #25 mclk = ~mclk;

    ppisc_top #(.HOLD_CYCLES(HOLD)) DUT (
        .mclk(mclk), .nrst(nrst), .io_enable_switch(io_en), .mode_switch(mode_sw),
        .cmd_word(cmd_word), .rd_addr(rd_addr), .rd_data_reg(rd_data_reg),
        .status_word_reg(status_word_reg), .comm_fault(comm_fault), .led_state(led),
        .modem_involved(inv), .forced_mode_valid(fv), .forced_mode(fm),
        .remote_out_set(oset), .pulse_alarm_active(pls), .sms_delivery(sms),
        .msg_done(msg_done), .alarm_start_reg(alarm_start_reg), .alarm_id_reg(alarm_id_reg),
        .call_end_reg(call_end_reg), .modem_reset_reg(modem_reset_reg), .dout_reg(dout_reg),
        .mode_led_green_reg(gled), .mode_led_red_reg(rled)
    );

    ppisc_modem_model #(.DELAY(3)) modem (
        .mclk(mclk), .nrst(nrst), .alarm_start(alarm_start_reg), .msg_done(msg_done)
    );

    task conclude;
        $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task chk_val(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task chk_cnt(input int got, input int exp);
        compares++;
        if (got != exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task run(input int cyc);
        ns = 0; ne = 0; fs = -1; nr = 0; id = 1'h0;
        for (int k = 1; k <= cyc; k++) begin
            @(negedge mclk);
            if (alarm_start_reg === 1'h1) begin
                if (fs < 0) begin
                    fs = k;
                    id = alarm_id_reg;
                end
                ns++;
            end
            if (call_end_reg === 1'h1) ne++;
            if (modem_reset_reg === 1'h1) nr++;
        end
    endtask

    initial begin
        repeat (20000) @(posedge mclk);
        n_mismatch++;
        conclude();
    end

    initial begin
        repeat (3) @(negedge mclk);
        chk_val(status_word_reg, 16'h0000); // reset
        chk_val({11'h000, dout_reg, modem_reset_reg}, 16'h0000); // reset
        repeat (2) @(negedge mclk);
        nrst = 1'h1;
        $display("test reset done");
        foreach (rows[i]) begin
            comm_fault = rows[i].flt; oset = rows[i].oset; pls = rows[i].pls;
            led = rows[i].led; inv = rows[i].inv; mode_sw = rows[i].sw;
            fv = rows[i].fv; fm = rows[i].fm; rd_addr = 1'h0;
            repeat (6) @(negedge mclk);
            chk_val(status_word_reg.lo, rows[i].lo);
            chk_val(status_word_reg.hi, rows[i].hi);
            chk_val(dout_reg, rows[i].dout);
            chk_val({gled, rled}, rows[i].gr);
            chk_val(rd_data_reg, rows[i].lo);
            rd_addr = 1'h1;
            repeat (2) @(negedge mclk);
            chk_val(rd_data_reg, rows[i].hi);
        end
        $display("test status rows done");
        comm_fault = 1'h0;
        for (int i = 0; i < 2; i++) begin
            sms = (i == 0);
            // held too short by the controller
            cmd_word = 16'h0040 << i;
            run(HOLD - 5);
            chk_cnt(ns, 0);
            cmd_word = 16'h0000;
            run(30);
            chk_cnt(ns, 0);
            // controller holds the bit long enough
            cmd_word = 16'h0040 << i;
            run(60);
            chk_cnt(ns, 1);
            chk_cnt(fs >= HOLD && fs <= HOLD + 4, 1);
            chk_val({15'h0000, id}, 16'(i));
            chk_cnt(ne, i == 0 ? 1 : 0);
            cmd_word = 16'h0000;
            run(5);
        end
        $display("test alarms done");
        cmd_word = 16'hFF3F;
        run(40);
        chk_cnt(nr, 16);
        chk_cnt(ns, 0);
        cmd_word = 16'h0000;
        run(5);
        $display("test modem reset done");
        // mid-run reset cuts a running modem reset pulse
        cmd_word = 16'h0100;
        run(3);
        chk_cnt(nr, 3);
        nrst = 1'h0;
        cmd_word = 16'h0000;
        repeat (2) @(negedge mclk);
        chk_val({15'h0000, modem_reset_reg}, 16'h0000);
        chk_val(status_word_reg, 16'h0000);
        nrst = 1'h1;
        run(6);
        chk_cnt(nr, 0);
        $display("test mid reset done");
        io_en = 1'h0;
        run(6);
        cmd_word = 16'h0140;
        run(40);
        chk_cnt(ns + nr, 0);
        chk_val(status_word_reg, 16'h0000);
        $display("test io disable done");
        conclude();
    end
endmodule
